//--- srse_chk.sv
/* port checker for srse_top.
   assumes one clock domain and an async active-high reset. */
`timescale 1ns/1ns
module srse_chk
(
  // clock and reset
  input wire logic        mclk,
  input wire logic        sys_rst,
  // register port
  input wire logic [6:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        reg_rvalid,
  // base settings and controls
  input wire logic [15:0] base_frequency,
  input wire logic [15:0] base_multiplier,
  input wire logic [15:0] synthesizer1_fec_numerator,
  input wire logic [15:0] synthesizer1_fec_denominator,
  input wire logic        synthesizer0_pll_source,
  input wire logic        synthesizer1_pll_source,
  input wire logic        synthesizer0_output_enable,
  input wire logic        synthesizer1_output_enable,
  input wire logic [51:0] synthesizer1_freq_hz,
  input wire logic        synthesizer1_freq_valid
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // reference quotient; a zero denominator saturates
  logic [51:0] exp_freq;
  assign exp_freq = (synthesizer1_fec_denominator == 16'h0000) ? '1 :
    (({36'h0, base_frequency} * {36'h0, base_multiplier}) << 4) *
    {36'h0, synthesizer1_fec_numerator} / {36'h0, synthesizer1_fec_denominator};
  ////////////////////////////////////////
  sequence s_ratio_wr;
    reg_wr && (reg_addr inside {7'h5c, 7'h5d, 7'h5e, 7'h5f});
  endsequence
  a_read_latency: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered one cycle later");
  a_rvalid_cause: assert property (!reg_rd |=> !reg_rvalid)
    else $error("read valid without a read");
  a_numer_byte: assert property (reg_wr && reg_addr == 7'h5c |=>
    synthesizer1_fec_numerator[15:8] == $past(reg_wdata)) else $error("numerator byte lost");
  a_denom_byte: assert property (reg_wr && reg_addr == 7'h5f |=>
    synthesizer1_fec_denominator[7:0] == $past(reg_wdata)) else $error("denominator byte lost");
  a_src_select: assert property (reg_wr && reg_addr == 7'h70 |=>
    synthesizer0_pll_source == $past(reg_wdata[0]) &&
    synthesizer1_pll_source == $past(reg_wdata[2])) else $error("pll source wrong");
  a_out_enable: assert property (reg_wr && reg_addr == 7'h71 |=>
    synthesizer0_output_enable == $past(reg_wdata[0]) &&
    synthesizer1_output_enable == $past(reg_wdata[1])) else $error("output enable wrong");
  a_valid_drop: assert property (s_ratio_wr |=> !synthesizer1_freq_valid)
    else $error("stale frequency still valid");
  a_freq_value: assert property ($rose(synthesizer1_freq_valid) |->
    synthesizer1_freq_hz == exp_freq) else $error("frequency value wrong");
endmodule // srse_chk

bind srse_top srse_chk srse_chk_i
(
  .mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .base_frequency(base_frequency), .base_multiplier(base_multiplier),
  .synthesizer1_fec_numerator(synthesizer1_fec_numerator),
  .synthesizer1_fec_denominator(synthesizer1_fec_denominator),
  .synthesizer0_pll_source(synthesizer0_pll_source),
  .synthesizer1_pll_source(synthesizer1_pll_source),
  .synthesizer0_output_enable(synthesizer0_output_enable),
  .synthesizer1_output_enable(synthesizer1_output_enable),
  .synthesizer1_freq_hz(synthesizer1_freq_hz), .synthesizer1_freq_valid(synthesizer1_freq_valid)
);

//--- srse_div_if.sv
/*
  start/done link between the frequency controller and its divider.
  assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
interface srse_div_if;
  logic                               start;
  logic [srse_pkg::DIVIDEND_W-1:0]    dividend;
  logic [srse_pkg::RATIO_W-1:0]       divisor;
  logic                               busy;
  logic                               done;
  logic [srse_pkg::DIVIDEND_W-1:0]    quotient;

  modport requester (output start, output dividend, output divisor,
                     input busy, input done, input quotient);
  modport divider   (input start, input dividend, input divisor,
                     output busy, output done, output quotient);
endinterface

//--- srse_divider.sv
/*
  sequential restoring divider, one quotient bit per clock.
  assumes start is raised only while busy is low.
*/
`timescale 1ns/1ns
module srse_divider
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // request and answer
  srse_div_if.divider      div
);

  localparam int unsigned DW = srse_pkg::DIVIDEND_W;
  localparam int unsigned RW = srse_pkg::RATIO_W;

  srse_pkg::srse_div_state_t state, next_state;
  logic [RW:0]                rem, next_rem;
  logic [DW-1:0]              quo, next_quo;
  logic [srse_pkg::STEP_W-1:0] step, next_step;
  logic                       done_q, next_done;
  logic [RW:0]                trial;
  logic [RW:0]                diff;

  ////////////////////////////////////////////////////////////////////////////
  // next state; a zero divisor yields all ones instead of a trap
  always_comb
  begin
    next_state = state;
    next_rem   = rem;
    next_quo   = quo;
    next_step  = step;
    next_done  = 1'b0;
    trial      = {rem[RW-1:0], quo[DW-1]};
    diff       = trial - {1'b0, div.divisor};
    unique case (state)
      srse_pkg::SRSE_DIV_IDLE:
      begin
        if (div.start)
        begin
          next_rem   = '0;
          next_quo   = div.dividend;
          next_step  = srse_pkg::STEP_ZERO;
          next_state = srse_pkg::SRSE_DIV_RUN;
        end
      end
      srse_pkg::SRSE_DIV_RUN:
      begin
        // divisor is sampled live; a ratio write while busy changes it, and that result is then left invalid
        if (trial >= {1'b0, div.divisor})
        begin
          next_rem = diff;
          next_quo = {quo[DW-2:0], 1'b1};
        end
        else
        begin
          next_rem = trial;
          next_quo = {quo[DW-2:0], 1'b0};
        end
        next_step = step + srse_pkg::STEP_ONE;
        if (step == srse_pkg::LAST_STEP)
        begin
          next_done  = 1'b1;
          next_state = srse_pkg::SRSE_DIV_IDLE;
        end
      end
    endcase
  end

  // registers only
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state  <= srse_pkg::SRSE_DIV_IDLE;
      rem    <= '0;
      quo    <= '0;
      step   <= srse_pkg::STEP_ZERO;
      done_q <= 1'b0;
    end
    else
    begin
      state  <= next_state;
      rem    <= next_rem;
      quo    <= next_quo;
      step   <= next_step;
      done_q <= next_done;
    end
  end

  assign div.busy     = (state == srse_pkg::SRSE_DIV_RUN);
  assign div.done     = done_q;
  assign div.quotient = quo;

endmodule // srse_divider

//--- srse_host.sv
/* host model driving the byte-wide register port.
   assumes the device answers reads one cycle after the strobe. */
`timescale 1ns/1ns
module srse_host
(
  // clock
  input wire logic        mclk,
  // register port
  output logic [6:0]      reg_addr,
  output logic            reg_wr,
  output logic [7:0]      reg_wdata,
  output logic            reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        reg_rvalid
);
  // idle bus at time zero
  initial
  begin
    reg_addr = 7'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end
  // one byte write; released lines show inverted data, not the last value
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    #1;
  endtask
  // one byte read; answer is settled just after the taking edge
  task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic v);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
    v = reg_rvalid;
  endtask
endmodule // srse_host

//--- srse_pkg.sv
/*
  constants shared by the synthesizer ratio, source-select and output-enable logic.
  assumes byte-wide register access with byte addresses as printed.
*/
package srse_pkg;

  // register port geometry
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DATA_W = 8;

  // byte addresses; the ratio word spans four bytes, most significant byte first
  localparam logic [ADDR_W-1:0] ADDR_RATIO_B3 = 7'h5c;
  localparam logic [ADDR_W-1:0] ADDR_RATIO_B2 = 7'h5d;
  localparam logic [ADDR_W-1:0] ADDR_RATIO_B1 = 7'h5e;
  localparam logic [ADDR_W-1:0] ADDR_RATIO_B0 = 7'h5f;
  localparam logic [ADDR_W-1:0] ADDR_SRC_SEL  = 7'h70;
  localparam logic [ADDR_W-1:0] ADDR_OUT_EN   = 7'h71;

  // reset values
  localparam logic [31:0]       RST_RATIO   = 32'h00010001;
  localparam logic [DATA_W-1:0] RST_SRC_SEL = 8'he4;
  localparam logic [DATA_W-1:0] RST_OUT_EN  = 8'h03;
  localparam logic [DATA_W-1:0] RD_UNMAPPED = 8'h00;

  // field layout
  localparam int unsigned RATIO_W      = 16;
  localparam int unsigned DENOM_LSB    = 0;
  localparam int unsigned NUMER_LSB    = 16;
  localparam int unsigned SYNTH0_SRC_B = 0;
  localparam int unsigned SYNTH1_SRC_B = 2;
  localparam int unsigned SYNTH0_EN_B  = 0;
  localparam int unsigned SYNTH1_EN_B  = 1;

  // frequency arithmetic: base * multiplier * 16 * numerator / denominator
  localparam int unsigned BASE_W      = 16;
  localparam int unsigned SCALE_SHIFT = 4;
  localparam int unsigned PROD_W      = 2 * BASE_W;
  localparam int unsigned DIVIDEND_W  = PROD_W + SCALE_SHIFT + RATIO_W;
  localparam int unsigned STEP_W      = 6;
  localparam logic [STEP_W-1:0] LAST_STEP = 6'h33;
  localparam logic [STEP_W-1:0] STEP_ZERO = 6'h00;
  localparam logic [STEP_W-1:0] STEP_ONE  = 6'h01;

  // controller and divider states
  typedef enum logic [1:0] {
    SRSE_CTL_IDLE = 2'b01,
    SRSE_CTL_WAIT = 2'b10
  } srse_ctl_state_t;

  typedef enum logic [1:0] {
    SRSE_DIV_IDLE = 2'b01,
    SRSE_DIV_RUN  = 2'b10
  } srse_div_state_t;

endpackage

//--- srse_top.sv
/*
  synthesizer 1 fec ratio, digital pll source selection and synthesizer output
  enables, with the resulting synthesizer 1 frequency in hertz.
  assumes the serial management port has been decoded into byte-wide register
  strobes on mclk, and that base frequency and multiplier come from mclk logic.
*/
// Behaviour
// - synthesizer frequency equals base times multiplier times 16 times numerator over denominator.
// - ratio register holds denominator in bits 15:0, numerator in bits 31:16.
// - source-select bit 0 picks pll for synthesizer 0: 0 first, 1 second.
// - source-select bit 2 picks pll for synthesizer 1, same encoding.
// - output-enable bit 0 set enables synthesizer 0 output regardless of bit 1.
// - output-enable bit 1 set enables synthesizer 1 output regardless of bit 0.
`timescale 1ns/1ns
module srse_top
(
  // clock and reset
  input  wire logic                               mclk,
  input  wire logic                               sys_rst,
  // register port
  input  wire logic [srse_pkg::ADDR_W-1:0]        reg_addr,
  input  wire logic                               reg_wr,
  input  wire logic [srse_pkg::DATA_W-1:0]        reg_wdata,
  input  wire logic                               reg_rd,
  output logic      [srse_pkg::DATA_W-1:0]        reg_rdata,
  output logic                                    reg_rvalid,
  // synthesizer 1 base settings from neighbouring registers
  input  wire logic [srse_pkg::BASE_W-1:0]        base_frequency,
  input  wire logic [srse_pkg::BASE_W-1:0]        base_multiplier,
  // synthesizer controls
  output logic      [srse_pkg::RATIO_W-1:0]       synthesizer1_fec_numerator,
  output logic      [srse_pkg::RATIO_W-1:0]       synthesizer1_fec_denominator,
  output logic                                    synthesizer0_pll_source,
  output logic                                    synthesizer1_pll_source,
  output logic                                    synthesizer0_output_enable,
  output logic                                    synthesizer1_output_enable,
  // computed synthesizer 1 frequency
  output logic      [srse_pkg::DIVIDEND_W-1:0]    synthesizer1_freq_hz,
  output logic                                    synthesizer1_freq_valid
);

  // register state
  logic [31:0]                     fec_ratio, next_fec_ratio;
  logic [srse_pkg::DATA_W-1:0]     source_select, next_source_select;
  logic [srse_pkg::DATA_W-1:0]     output_enable, next_output_enable;
  logic [srse_pkg::DATA_W-1:0]     rdata, next_rdata;
  logic                            rvalid, next_rvalid;

  // frequency controller state
  srse_pkg::srse_ctl_state_t       ctl, next_ctl;
  logic                            dirty, next_dirty;
  logic [srse_pkg::BASE_W-1:0]     used_base, next_used_base;
  logic [srse_pkg::BASE_W-1:0]     used_mult, next_used_mult;
  logic [srse_pkg::DIVIDEND_W-1:0] freq, next_freq;
  logic                            freq_ok, next_freq_ok;
  logic                            ratio_hit;
  logic [4:0]                      addr_lane;
  logic                            base_moved;
  logic [srse_pkg::PROD_W-1:0]     prod;
  logic [srse_pkg::PROD_W+srse_pkg::SCALE_SHIFT-1:0] scaled;

  srse_div_if div ();

  // byte lane of the ratio word for an address, or none
  function automatic logic [4:0] ratio_lane(input logic [srse_pkg::ADDR_W-1:0] a);
    logic [4:0] lane;
    lane = 5'h00;
    if (a == srse_pkg::ADDR_RATIO_B3) lane = 5'h13;
    if (a == srse_pkg::ADDR_RATIO_B2) lane = 5'h12;
    if (a == srse_pkg::ADDR_RATIO_B1) lane = 5'h11;
    if (a == srse_pkg::ADDR_RATIO_B0) lane = 5'h10;
    return lane;                   // bit 4 flags a hit, bits 1:0 the lane
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register writes and reads; reserved bits are stored as written
  always_comb
  begin
    logic [4:0] wl;
    logic [4:0] rl;
    wl = ratio_lane(reg_addr);
    rl = ratio_lane(reg_addr);
    next_fec_ratio     = fec_ratio;
    next_source_select = source_select;
    next_output_enable = output_enable;
    next_rdata         = rdata;
    next_rvalid        = reg_rd;
    if (reg_wr)
    begin
      if (wl[4])
        next_fec_ratio[wl[1:0]*srse_pkg::DATA_W +: srse_pkg::DATA_W] = reg_wdata;
      if (reg_addr == srse_pkg::ADDR_SRC_SEL)
        next_source_select = reg_wdata;
      if (reg_addr == srse_pkg::ADDR_OUT_EN)
        next_output_enable = reg_wdata;
    end
    if (reg_rd)
    begin
      next_rdata = srse_pkg::RD_UNMAPPED;
      if (rl[4])
        next_rdata = fec_ratio[rl[1:0]*srse_pkg::DATA_W +: srse_pkg::DATA_W];
      if (reg_addr == srse_pkg::ADDR_SRC_SEL)
        next_rdata = source_select;
      if (reg_addr == srse_pkg::ADDR_OUT_EN)
        next_rdata = output_enable;
    end
  end

  // reset gives a unity ratio, so plain rates need no ratio write
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      fec_ratio     <= srse_pkg::RST_RATIO;
      source_select <= srse_pkg::RST_SRC_SEL;
      output_enable <= srse_pkg::RST_OUT_EN;
      rdata         <= srse_pkg::RD_UNMAPPED;
      rvalid        <= 1'b0;
    end
    else
    begin
      fec_ratio     <= next_fec_ratio;
      source_select <= next_source_select;
      output_enable <= next_output_enable;
      rdata         <= next_rdata;
      rvalid        <= next_rvalid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control outputs straight from the stored fields
  assign synthesizer1_fec_denominator = fec_ratio[srse_pkg::DENOM_LSB +: srse_pkg::RATIO_W];
  assign synthesizer1_fec_numerator   = fec_ratio[srse_pkg::NUMER_LSB +: srse_pkg::RATIO_W];
  assign synthesizer0_pll_source      = source_select[srse_pkg::SYNTH0_SRC_B];
  assign synthesizer1_pll_source      = source_select[srse_pkg::SYNTH1_SRC_B];
  assign synthesizer0_output_enable   = output_enable[srse_pkg::SYNTH0_EN_B];
  assign synthesizer1_output_enable   = output_enable[srse_pkg::SYNTH1_EN_B];
  assign reg_rdata                    = rdata;
  assign reg_rvalid                   = rvalid;

  ////////////////////////////////////////////////////////////////////////////
  // frequency recompute; each ratio byte write marks it dirty for a new run after any run in progress, so the value
  // between the bytes of one update is briefly computed and then replaced
  assign prod        = base_frequency * base_multiplier;
  assign scaled      = {prod, {srse_pkg::SCALE_SHIFT{1'b0}}};
  assign addr_lane   = ratio_lane(reg_addr);
  assign ratio_hit   = reg_wr && addr_lane[4];
  assign base_moved  = (base_frequency != used_base) || (base_multiplier != used_mult);
  assign div.dividend = scaled * synthesizer1_fec_numerator;
  assign div.divisor  = synthesizer1_fec_denominator;
  assign div.start    = (ctl == srse_pkg::SRSE_CTL_IDLE) && dirty && !div.busy;

  always_comb
  begin
    next_ctl       = ctl;
    next_dirty     = dirty;
    next_used_base = used_base;
    next_used_mult = used_mult;
    next_freq      = freq;
    next_freq_ok   = freq_ok;
    unique case (ctl)
      srse_pkg::SRSE_CTL_IDLE:
      begin
        if (div.start)
        begin
          next_dirty     = 1'b0;
          next_used_base = base_frequency;
          next_used_mult = base_multiplier;
          next_freq_ok   = 1'b0;
          next_ctl       = srse_pkg::SRSE_CTL_WAIT;
        end
      end
      srse_pkg::SRSE_CTL_WAIT:
      begin
        if (div.done)
        begin
          next_freq    = div.quotient;
          next_freq_ok = !dirty;
          next_ctl     = srse_pkg::SRSE_CTL_IDLE;
        end
      end
    endcase
    // a change during a calculation or in its start cycle must not be lost;
    // a moved base also withdraws valid at once, so a stale rate never shows
    if (ratio_hit || (base_moved && !div.start))
      next_dirty = 1'b1;
    if (ratio_hit || base_moved)
      next_freq_ok = 1'b0;
  end

  // dirty starts set so the reset ratio is evaluated once
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctl       <= srse_pkg::SRSE_CTL_IDLE;
      dirty     <= 1'b1;
      used_base <= '0;
      used_mult <= '0;
      freq      <= '0;
      freq_ok   <= 1'b0;
    end
    else
    begin
      ctl       <= next_ctl;
      dirty     <= next_dirty;
      used_base <= next_used_base;
      used_mult <= next_used_mult;
      freq      <= next_freq;
      freq_ok   <= next_freq_ok;
    end
  end

  assign synthesizer1_freq_hz    = freq;
  assign synthesizer1_freq_valid = freq_ok;

  srse_divider u_div
  (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .div     (div.divider)
  );

endmodule // srse_top

//--- srse_top_tb.sv
/* self-checking bench for srse_top with a host model on the register port.
   assumes a 100 MHz clock and base settings driven from the bench. */
`timescale 1ns/1ns
module srse_top_tb;
  logic        mclk, sys_rst, reg_wr, reg_rd, reg_rvalid, rv;
  logic [6:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, rdat, d;
  logic [15:0] bf, bm, num, den;
  logic        src0, src1, en0, en1, fvalid;
  logic [51:0] fhz;
  int          fails, samples_checked;
  always #5 mclk = ~mclk;
  srse_top srse_top_i (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .base_frequency(bf), .base_multiplier(bm),
    .synthesizer1_fec_numerator(num), .synthesizer1_fec_denominator(den),
    .synthesizer0_pll_source(src0), .synthesizer1_pll_source(src1),
    .synthesizer0_output_enable(en0), .synthesizer1_output_enable(en1),
    .synthesizer1_freq_hz(fhz), .synthesizer1_freq_valid(fvalid));
  srse_host srse_host_i (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  ////////////////////////////////////////
  // compare and count
  task automatic chk(input logic [51:0] seen, input logic [51:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // read one byte and compare, including the valid pulse
  task automatic rchk(input logic [6:0] a, input logic [7:0] e);
    srse_host_i.rd(a, rdat, rv);
    chk({51'h0, rv}, 52'h1);
    chk({44'h0, rdat}, {44'h0, e});
  endtask
  // bounded wait for a finished calculation, then check the quotient
  task automatic freq_chk(input logic [15:0] m, input logic [15:0] n);
    int k;
    k = 0;
    #1;
    while (fvalid !== 1'b1 && k < 300)
    begin
      @(posedge mclk);
      #1;
      k++;
    end
    chk({51'h0, fvalid}, 52'h1);
    chk(fhz, (({36'h0, bf} * {36'h0, bm}) << 4) * {36'h0, m} / {36'h0, n});
  endtask
  task automatic t_reset;
    rchk(7'h5c, 8'h00);
    rchk(7'h5d, 8'h01);
    rchk(7'h5e, 8'h00);
    rchk(7'h5f, 8'h01);
    rchk(7'h70, 8'he4);
    rchk(7'h71, 8'h03);
    rchk(7'h7f, 8'h00);
    chk({48'h0, src1, src0, en1, en0}, 52'hb);
    freq_chk(16'h0001, 16'h0001);
  endtask
  // fec ratio 255/237, then unity again, then a new base rate
  task automatic t_ratio;
    srse_host_i.wr(7'h5c, 8'h00);
    srse_host_i.wr(7'h5d, 8'hff);
    srse_host_i.wr(7'h5e, 8'h00);
    srse_host_i.wr(7'h5f, 8'hed);
    chk({36'h0, num, den}, {36'h0, 16'h00ff, 16'h00ed});
    freq_chk(16'h00ff, 16'h00ed);
    rchk(7'h5d, 8'hff);
    rchk(7'h5f, 8'hed);
    srse_host_i.wr(7'h5d, 8'h01);
    srse_host_i.wr(7'h5f, 8'h01);
    freq_chk(16'h0001, 16'h0001);
    @(posedge mclk);
    bf <= 16'h61a8;
    bm <= 16'h0c35;
    repeat (3) @(posedge mclk);
    freq_chk(16'h0001, 16'h0001);
    // base moved again while a calculation runs; only the final rate turns valid
    @(posedge mclk);
    bf <= 16'h9c40;
    bm <= 16'h0798;
    repeat (10) @(posedge mclk);
    bf <= 16'h61a8;
    bm <= 16'h0c35;
    freq_chk(16'h0001, 16'h0001);
  endtask
  // every source pairing, reserved bits kept at default
  task automatic t_src;
    for (int i = 0; i < 4; i++)
    begin
      d = 8'he0 | {5'h0, i[1], 1'b0, i[0]};
      srse_host_i.wr(7'h70, d);
      chk({50'h0, src1, src0}, 52'(i));
      rchk(7'h70, d);
    end
    srse_host_i.wr(7'h72, 8'h55);
    rchk(7'h72, 8'h00);
    rchk(7'h70, 8'he5);
  endtask
  // every enable pattern, ending at the default
  task automatic t_en;
    for (int i = 0; i < 4; i++)
    begin
      srse_host_i.wr(7'h71, 8'(i));
      chk({50'h0, en1, en0}, 52'(i));
    end
    rchk(7'h71, 8'h03);
  endtask
  ////////////////////////////////////////
  task automatic test_done;
    $display("samples_checked=%0d fails=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // main sequence; 1.24416 GHz base keeps the synthesizer in range
  initial
  begin
    mclk = 1'b0;
    sys_rst = 1'b1;
    bf = 16'h9c40;
    bm = 16'h0798;
    fails = 0;
    samples_checked = 0;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    t_reset;
    t_ratio;
    t_src;
    t_en;
    test_done;
  end
  // watchdog, well beyond the few hundred cycles the tests need
  initial
  begin
    #200000;
    fails++;
    test_done;
  end
endmodule // srse_top_tb
